// [dv/testbench.sv]
// self-checking bench for the cache access port
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module testbench;
  logic clock_i, rst_i, req_valid_i, ready_o, ack_o, wb_valid_o, wb_ready_i;
  mmc_pkg::req_t req_i;
  mmc_pkg::word_t rdata_o, rd;
  mmc_pkg::wb_t wb_o, last;
  logic [3:0] stall;
  int taken, base, fail_count, checks_done, i;
  typedef struct packed {logic wr; mmc_pkg::word_t addr; mmc_pkg::word_t wdata; mmc_pkg::word_t exp;} row_t;
  row_t rows [13] = '{
    '{1'b1, 32'hF0001080, 32'h01100051, 32'h0}, '{1'b0, 32'hF0001080, 32'h0, 32'h01100051},
    '{1'b0, 32'hF0001088, 32'h0, 32'h01100051}, '{1'b1, 32'hF1001080, 32'h11111111, 32'h0},
    '{1'b1, 32'hF1001084, 32'h22222222, 32'h0}, '{1'b1, 32'hF1001088, 32'h33333333, 32'h0},
    '{1'b1, 32'hF100108C, 32'h44444444, 32'h0}, '{1'b0, 32'hF1001080, 32'h0, 32'h11111111},
    '{1'b0, 32'hF1001088, 32'h0, 32'h33333333}, '{1'b0, 32'hF1FFD08C, 32'h0, 32'h44444444},
    '{1'b0, 32'hF0001080, 32'h0, 32'h01100051}, '{1'b0, 32'hF2001080, 32'h0, 32'h0},
    '{1'b1, 32'hF0001080, 32'h01100053, 32'h0}};

  cache_map_port dut (.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .ready_o(ready_o), .ack_o(ack_o), .rdata_o(rdata_o), .wb_valid_o(wb_valid_o), .wb_o(wb_o),
    .wb_ready_i(wb_ready_i));
  wb_sink mem (.clock_i(clock_i), .rst_i(rst_i), .wb_valid_i(wb_valid_o), .wb_i(wb_o), .stall_i(stall),
    .wb_ready_o(wb_ready_i), .last_o(last), .taken_o(taken));

  // ==========
  // tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // request held over the taking edge, answer read in the ack cycle
  task automatic access(input logic wr, input mmc_pkg::word_t a, input mmc_pkg::word_t d,
    output mmc_pkg::word_t q);
    int n;
    req_i = '{write: wr, addr: a, wdata: d};
    req_valid_i = 1'b1;
    @(posedge clock_i);
    #1;
    req_valid_i = 1'b0;
    for (n = 0; n < 60 && ack_o !== 1'b1; n++)
    begin
      @(posedge clock_i);
      #1;
    end
    `CHK(ack_o, 1'b1)
    q = rdata_o;
  endtask

  // ==========
  // clock, watchdog
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  initial
  begin
    #100000;
    fail_count++;
    report_and_stop();
  end

  // ==========
  // sequence
  initial
  begin
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    stall = 4'h0;
    fail_count = 0;
    checks_done = 0;
    repeat (5) @(posedge clock_i);
    #1;
    `CHK({ready_o, ack_o, wb_valid_o}, 3'b100)
    rst_i = 1'b0;
    @(posedge clock_i);
    #1;
    // arrays come up unknown, so clear the tag/state word of every entry and way first
    for (i = 0; i < 1024; i++)
      access(1'b1, 32'hF0000000 + 32'(i * 16), 32'h0, rd);
    foreach (rows[k])
    begin
      access(rows[k].wr, rows[k].addr, rows[k].wdata, rd);
      if (!rows[k].wr)
        `CHK(rd, rows[k].exp)
    end
    // direct overwrite of a dirty valid line, memory stalling
    base = taken;
    stall = 4'h3;
    access(1'b1, 32'hF0001080, 32'h0, rd);
    `CHK(taken - base, 1)
    `CHK(last, {28'h0110008, 32'h44444444, 32'h33333333, 32'h22222222, 32'h11111111})
    access(1'b0, 32'hF0001080, 32'h0, rd);
    `CHK(rd, 32'h0)
    // compare write: dirty hit in way 2
    for (i = 0; i < 4; i++)
      access(1'b1, 32'hF1002080 + 32'(i * 4), 32'hA0 + 32'(i), rd);
    access(1'b1, 32'hF0002080, 32'h01100053, rd);
    base = taken;
    access(1'b1, 32'hF0000088, 32'h01100000, rd);
    `CHK(taken - base, 1)
    `CHK(last, {28'h0110008, 32'hA3, 32'hA2, 32'hA1, 32'hA0})
    access(1'b0, 32'hF0002080, 32'h0, rd);
    `CHK(rd, 32'h01100050)
    // same tag but now invalid: no hit, nothing changes
    access(1'b1, 32'hF0000088, 32'h01100003, rd);
    access(1'b0, 32'hF0002080, 32'h0, rd);
    `CHK(rd, 32'h01100050)
    // clean hit in way 3: flags change, no write-back
    access(1'b1, 32'hF0003080, 32'h02200041, rd);
    access(1'b1, 32'hF0000088, 32'h02200000, rd);
    `CHK(taken - base, 1)
    access(1'b0, 32'hF0003080, 32'h0, rd);
    `CHK(rd, 32'h02200040)
    // mid-run reset clears the outputs but keeps the arrays
    rst_i = 1'b1;
    @(posedge clock_i);
    #1;
    `CHK({ready_o, ack_o, wb_valid_o, rdata_o, wb_o}, {3'b100, 32'h0, 156'h0})
    rst_i = 1'b0;
    access(1'b0, 32'hF0003080, 32'h0, rd);
    `CHK(rd, 32'h02200040)
    report_and_stop();
  end
endmodule

// [dv/wb_sink.sv]
// write-back memory model that takes offered lines after a chosen stall
`timescale 1ns/1ns
module wb_sink (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // line offer from the port
  input wire logic wb_valid_i,
  input wire mmc_pkg::wb_t wb_i,
  input wire logic [3:0] stall_i,
  output logic wb_ready_o,
  // record of taken lines
  output mmc_pkg::wb_t last_o,
  output int taken_o
);
  logic [3:0] wait_cnt;

  // ready only after the stall, dropped right after each take
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wb_ready_o <= 1'b0;
      wait_cnt <= 4'h0;
      taken_o <= 0;
      last_o <= '0;
    end
    else if (wb_valid_i && wb_ready_o)
    begin
      wb_ready_o <= 1'b0;
      wait_cnt <= 4'h0;
      taken_o <= taken_o + 1;
      last_o <= wb_i;
    end
    else if (wb_valid_i && wait_cnt >= stall_i)
      wb_ready_o <= 1'b1;
    else if (wb_valid_i)
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

// [rtl/cache_map_port.sv]
// software access port into the tag/state and data arrays of the four-way cache
// Function
// - region F0 top byte reaches tag/state array, F1 reaches data array
// - tag access: entry bits 11-4, way bits 13-12, compare flag bit 3
// - tag word: tag 31-10, order bits 9-4, dirty bit 1, valid bit 0
// - tag read returns addressed way fields, never compares
// - direct write over dirty valid line writes it back first
// - compare write updates only dirty and valid of hitting way
// - compare write with no hit changes nothing
// - compare write writes hitting line back when dirty
// - data access: entry 11-4, way 13-12, longword 3-2, top byte F1
// - longword code 00 to 11 selects longwords 0 to 3
// - data array accesses never alter tag/state fields
// - data read returns selected longword of addressed line
// - data write stores word at selected longword position
// - compare hit needs equal tag and valid set
`timescale 1ns/1ns
module cache_map_port (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // cpu request
  input wire logic req_valid_i,
  input wire mmc_pkg::req_t req_i,
  output logic ready_o,
  // cpu answer
  output logic ack_o,
  output mmc_pkg::word_t rdata_o,
  // line write-back to memory
  output logic wb_valid_o,
  output mmc_pkg::wb_t wb_o,
  input wire logic wb_ready_i
);

  // ==========================================================================
  // state
  typedef enum logic [2:0] {S_IDLE, S_LOOK, S_EVAL, S_LINE, S_FETCH, S_WB, S_WRITE} state_t;

  state_t state;
  state_t next_state;
  mmc_pkg::req_t req;
  mmc_pkg::req_t next_req;
  mmc_pkg::way_t tgt_way;
  mmc_pkg::way_t next_tgt_way;
  logic ack;
  logic next_ack;
  mmc_pkg::word_t rdata;
  mmc_pkg::word_t next_rdata;
  logic ready;
  logic next_ready;
  logic wb_valid;
  logic next_wb_valid;
  mmc_pkg::wb_t wb;
  mmc_pkg::wb_t next_wb;

  // ==========================================================================
  // address decode
  mmc_pkg::entry_t entry;
  mmc_pkg::way_t way;
  mmc_pkg::lw_t lw;
  logic assoc;
  logic is_tag;
  logic is_data;

  assign entry = req.addr[mmc_pkg::ENTRY_MSB:mmc_pkg::ENTRY_LSB];
  assign way = req.addr[mmc_pkg::WAY_MSB:mmc_pkg::WAY_LSB];
  assign lw = req.addr[mmc_pkg::LW_MSB:mmc_pkg::LW_LSB];
  assign assoc = req.addr[mmc_pkg::ASSOC_BIT];
  // only the top byte picks the array; every other free bit is ignored
  assign is_tag = req.addr[mmc_pkg::REGION_MSB:mmc_pkg::REGION_LSB] == mmc_pkg::REGION_TAG;
  assign is_data = req.addr[mmc_pkg::REGION_MSB:mmc_pkg::REGION_LSB] == mmc_pkg::REGION_DATA;

  // ==========================================================================
  // arrays
  mmc_pkg::tag_row_t tag_rdata;
  mmc_pkg::tag_row_t tag_wdata;
  logic tag_we;
  mmc_pkg::line_t data_rdata;
  mmc_pkg::line_t data_wdata;
  logic data_we;
  logic [mmc_pkg::ENTRY_W+mmc_pkg::WAY_W-1:0] data_raddr;
  logic [mmc_pkg::ENTRY_W+mmc_pkg::WAY_W-1:0] data_waddr;

  // a whole row holds all four ways so the compare sees them at once
  cache_ram #(
    .WIDTH($bits(mmc_pkg::tag_row_t)),
    .DEPTH(mmc_pkg::ENTRIES),
    .AW(mmc_pkg::ENTRY_W)
  ) u_tag_ram (
    .clock_i(clock_i),
    .write_i(tag_we),
    .waddr_i(entry),
    .wdata_i(tag_wdata),
    .raddr_i(entry),
    .rdata_o(tag_rdata)
  );

  assign data_raddr = {entry, tgt_way};
  assign data_waddr = {entry, way};

  cache_ram #(
    .WIDTH($bits(mmc_pkg::line_t)),
    .DEPTH(mmc_pkg::ENTRIES * mmc_pkg::WAYS),
    .AW(mmc_pkg::ENTRY_W + mmc_pkg::WAY_W)
  ) u_data_ram (
    .clock_i(clock_i),
    .write_i(data_we),
    .waddr_i(data_waddr),
    .wdata_i(data_wdata),
    .raddr_i(data_raddr),
    .rdata_o(data_rdata)
  );

  // ==========================================================================
  // tag compare
  logic any_hit;
  mmc_pkg::way_t hit_way;
  mmc_pkg::tag_word_t wr_word;

  assign wr_word = mmc_pkg::tag_word_t'(req.wdata);

  // lowest hitting way wins; software keeps tags unique per entry
  always_comb
  begin
    any_hit = 1'b0;
    hit_way = '0;
    for (int w = mmc_pkg::WAYS - 1; w >= 0; w--)
    begin
      if (tag_rdata[w].valid && tag_rdata[w].tag == wr_word.tag)
      begin
        any_hit = 1'b1;
        hit_way = mmc_pkg::way_t'(w);
      end
    end
  end

  // ==========================================================================
  // sequencer
  always_comb
  begin
    next_state = state;
    next_req = req;
    next_tgt_way = tgt_way;
    next_ack = 1'b0;
    next_rdata = rdata;
    next_wb_valid = wb_valid;
    next_wb = wb;
    tag_we = 1'b0;
    tag_wdata = tag_rdata;
    data_we = 1'b0;
    data_wdata = data_rdata;
    case (state)
      S_IDLE:
      begin
        if (req_valid_i)
        begin
          next_req = req_i;
          next_tgt_way = req_i.addr[mmc_pkg::WAY_MSB:mmc_pkg::WAY_LSB];
          next_state = S_LOOK;
        end
      end
      S_LOOK:
      begin
        next_state = S_EVAL;
      end
      S_EVAL:
      begin
        next_ack = 1'b1;
        next_state = S_IDLE;
        if (is_data)
        begin
          // tag row is not written on this path
          if (req.write)
          begin
            data_wdata[lw] = req.wdata;
            data_we = 1'b1;
          end
          else
          begin
            next_rdata = data_rdata[lw];
          end
        end
        else if (is_tag)
        begin
          if (!req.write)
          begin
            next_rdata = tag_rdata[way];
          end
          else if (!assoc)
          begin
            next_ack = 1'b0;
            if (tag_rdata[way].dirty && tag_rdata[way].valid)
              next_state = S_LINE;
            else
              next_state = S_WRITE;
          end
          else if (any_hit)
          begin
            next_ack = 1'b0;
            next_tgt_way = hit_way;
            next_state = tag_rdata[hit_way].dirty ? S_LINE : S_WRITE;
          end
          // no hit: answered with nothing written
        end
        else
        begin
          next_rdata = '0;
        end
      end
      S_LINE:
      begin
        // data read address moved to the target way, one cycle to settle
        next_state = S_FETCH;
      end
      S_FETCH:
      begin
        next_wb_valid = 1'b1;
        next_wb.line_addr = {tag_rdata[tgt_way].tag, entry[mmc_pkg::ENTRY_LOW_W-1:0]};
        next_wb.data = data_rdata;
        next_state = S_WB;
      end
      S_WB:
      begin
        // new fields are stored only once memory took the old line
        if (wb_ready_i)
        begin
          next_wb_valid = 1'b0;
          next_state = S_WRITE;
        end
      end
      S_WRITE:
      begin
        tag_we = 1'b1;
        if (assoc)
        begin
          tag_wdata[tgt_way].dirty = wr_word.dirty;
          tag_wdata[tgt_way].valid = wr_word.valid;
        end
        else
        begin
          tag_wdata[tgt_way] = wr_word;
          tag_wdata[tgt_way].rsv = mmc_pkg::RSV_ZERO;
        end
        next_ack = 1'b1;
        next_state = S_IDLE;
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
    next_ready = next_state == S_IDLE;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      req <= '0;
      tgt_way <= '0;
      ack <= 1'b0;
      rdata <= '0;
      ready <= 1'b1;
      wb_valid <= 1'b0;
      wb <= '0;
    end
    else
    begin
      state <= next_state;
      req <= next_req;
      tgt_way <= next_tgt_way;
      ack <= next_ack;
      rdata <= next_rdata;
      ready <= next_ready;
      wb_valid <= next_wb_valid;
      wb <= next_wb;
    end
  end

  assign ready_o = ready;
  assign ack_o = ack;
  assign rdata_o = rdata;
  assign wb_valid_o = wb_valid;
  assign wb_o = wb;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  logic taken;
  logic eval_direct;
  logic eval_assoc;

  assign taken = state == S_IDLE && req_valid_i;
  assign eval_direct = state == S_EVAL && is_tag && req.write && !assoc;
  assign eval_assoc = state == S_EVAL && is_tag && req.write && assoc;

  a_read_answer_time: assert property (taken && !req_i.write |-> ##3 ack_o)
    else $error("read not answered three cycles after it was taken");
  a_tag_read_value: assert property (state == S_EVAL && is_tag && !req.write |=> rdata_o == $past(tag_rdata[way]))
    else $error("tag read returned wrong fields");
  a_data_read_value: assert property (state == S_EVAL && is_data && !req.write |=> rdata_o == $past(data_rdata[lw]))
    else $error("data read returned wrong longword");
  a_data_write_place: assert property (data_we |-> data_wdata[lw] == req.wdata && data_waddr == {entry, way})
    else $error("data write landed in wrong place");
  a_data_keeps_tags: assert property (state == S_EVAL && is_data |-> !tag_we ##1 !tag_we)
    else $error("data access wrote the tag array");
  a_dirty_written_back: assert property (eval_direct && tag_rdata[way].dirty && tag_rdata[way].valid |-> ##3 wb_valid_o)
    else $error("dirty line overwritten without write-back");
  a_hit_dirty_back: assert property (eval_assoc && any_hit && tag_rdata[hit_way].dirty |-> ##3 wb_valid_o)
    else $error("dirty hitting line not written back");
  a_miss_no_write: assert property (eval_assoc && !any_hit |-> !tag_we ##1 (ack_o && !tag_we && !wb_valid_o))
    else $error("compare write without hit changed the cache");
  a_assoc_keeps_tag: assert property (tag_we && assoc |-> tag_wdata[tgt_way].tag == tag_rdata[tgt_way].tag
    && tag_wdata[tgt_way].lru == tag_rdata[tgt_way].lru)
    else $error("compare write changed tag or order bits");
  a_hit_needs_valid: assert property (any_hit |-> tag_rdata[hit_way].valid)
    else $error("hit reported on invalid way");
  a_wb_before_store: assert property (wb_valid_o && !wb_ready_i |=> wb_valid_o && $stable(wb_o) && !tag_we)
    else $error("write-back dropped or changed while waiting");

  c_tag_read: cover property (state == S_EVAL && is_tag && !req.write);
  c_purge_dirty: cover property (eval_assoc && any_hit && tag_rdata[hit_way].dirty);
  c_assoc_miss: cover property (eval_assoc && !any_hit);
  c_data_write: cover property (data_we);

endmodule

// [rtl/cache_ram.sv]
// simple one-write one-read array with registered read data
`timescale 1ns/1ns
module cache_ram #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // clock
  input wire logic clock_i,
  // write port
  input wire logic write_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // read port
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  // no reset: array contents are undefined until software initialises them
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock_i)
  begin
    if (write_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

// [rtl/mmc_pkg.sv]
// shared constants and types for the memory-mapped cache access port
package mmc_pkg;

  // ==========================================================================
  // geometry
  localparam int WAYS = 4;
  localparam int ENTRIES = 256;
  localparam int LINE_WORDS = 4;
  localparam int ENTRY_W = 8;
  localparam int WAY_W = 2;
  localparam int LW_W = 2;

  // ==========================================================================
  // address decode
  localparam logic [7:0] REGION_TAG = 8'hF0;
  localparam logic [7:0] REGION_DATA = 8'hF1;
  localparam int REGION_LSB = 24;
  localparam int REGION_MSB = 31;
  localparam int WAY_LSB = 12;
  localparam int WAY_MSB = 13;
  localparam int ENTRY_LSB = 4;
  localparam int ENTRY_MSB = 11;
  localparam int ASSOC_BIT = 3;
  localparam int LW_LSB = 2;
  localparam int LW_MSB = 3;

  // ==========================================================================
  // tag/state word layout
  localparam int TAG_W = 22;
  localparam int LRU_W = 6;
  localparam int RSV_W = 2;
  localparam int LINE_ADDR_W = 28;
  // entry bits below the tag's lowest bit complete the line address
  localparam int ENTRY_LOW_W = LINE_ADDR_W - TAG_W;
  localparam logic [RSV_W-1:0] RSV_ZERO = 2'h0;

  typedef logic [31:0] word_t;
  typedef logic [ENTRY_W-1:0] entry_t;
  typedef logic [WAY_W-1:0] way_t;
  typedef logic [LW_W-1:0] lw_t;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [LRU_W-1:0] lru;
    logic [RSV_W-1:0] rsv;
    logic dirty;
    logic valid;
  } tag_word_t;

  typedef tag_word_t [WAYS-1:0] tag_row_t;
  typedef word_t [LINE_WORDS-1:0] line_t;

  typedef struct packed {
    logic write;
    word_t addr;
    word_t wdata;
  } req_t;

  typedef struct packed {
    logic [LINE_ADDR_W-1:0] line_addr;
    line_t data;
  } wb_t;

endpackage
